// ==== src/dtd_decoder.sv ====
// How it works
// - direction bit one makes register the destination
// - width bit set means word, clear byte
// - sign bit clear takes full-width immediate, else extends
// - displacement bytes come before any immediate data
// - register operand lower count, memory operand higher
// - three-term offset sum adds one cycle
// - segment load 2/5 real, 17/19 protected
// - protected-only opcode in real mode faults 6
// - real word access at ffff faults 13
// - real flag pop zeroes threshold and nest
// - real coprocessor operand past limit faults 9
// - exchange always asserts bus lock
// - lock may drop between operand transfers
// - protected operand breach 13, stack breach 12
// - segment load checks privilege, absence 11/12
// - descriptor table accesses assert bus lock
// - port access above threshold faults 13
// - flag pop guards interrupt bit and threshold
// - escape start breach 13/12, transfer breach 9
// - selector check violation clears zero, no result
// - transfer target outside code limit faults 13
module dtd_decoder (
   // clock and reset
   input  wire  logic                i_core_clk,
   input  wire  logic                i_rst,
   // instruction from the prefetch queue
   input  wire  logic                i_valid,
   input  wire  dtd_pkg::dtd_instr_t i_instr,
   input  wire  dtd_pkg::dtd_env_t   i_env,
   input  wire  logic [15:0]         i_cur_flags,
   input  wire  logic [15:0]         i_popped_flags,
   output logic                      o_ready,
   // decoded result to execution
   output logic                      o_commit,
   output dtd_pkg::dtd_dec_t         o_dec,
   output logic [15:0]               o_flags,
   output logic                      o_lock,
   // fault handshake to the exception unit
   output logic                      o_fault_valid,
   output logic [7:0]                o_fault_vector,
   input  wire  logic                i_fault_ready
);
   import dtd_pkg::*;

   dtd_state_t  state_r;        // run or waiting on exception unit
   dtd_dec_t    dec_nxt;        // combinational decode
   logic        fault_nxt;      // decode found a fault
   logic [7:0]  vec_nxt;        // its vector
   logic        lock_nxt;       // bus lock request
   logic [15:0] flags_nxt;      // flag word after this instruction
   logic        accept;         // instruction taken this cycle

   assign accept = i_valid && o_ready;

   // combinational decode of one instruction
   always_comb begin
      logic [7:0] op;
      logic [1:0] md;
      logic [2:0] rm;
      logic       mem;
      logic       cls_mov, cls_movi, cls_seg, cls_exchange_instruction, cls_imm;
      logic       cls_port, cls_esc, cls_pop_flag_word_instruction, cls_ctl, cls_sys;
      logic [4:0] reg_c, mem_c;
      logic [31:0] after;
      op       = i_instr.opcode;
      md       = i_instr.modrm[7:6];
      rm       = i_instr.modrm[2:0];
      mem      = 1'b0;
      reg_c    = CYC_DEFAULT;
      mem_c    = CYC_DEFAULT_M;
      after    = 32'h0;
      dec_nxt  = '0;
      fault_nxt = 1'b0;
      vec_nxt  = 8'h00;
      lock_nxt = 1'b0;
      flags_nxt = i_cur_flags;
      cls_mov  = (op[7:2] == OP_MOV_RM);
      cls_movi = (op[7:1] == OP_MOV_IMM_RM);
      cls_seg  = (op == OP_SEG_LOAD);
      cls_exchange_instruction = (op[7:1] == OP_EXCHANGE_INSTRUCTION_RM);
      cls_imm  = (op[7:2] == OP_IMM_GRP);
      cls_port = (op[7:4] == OP_PORT_HI) && op[2];
      cls_esc  = (op[7:3] == OP_ESCAPE);
      cls_pop_flag_word_instruction = (op == OP_POP_FLAGS);
      cls_sys  = (op == OP_TWO_BYTE);
      cls_ctl  = (op == OP_CALL_NEAR) || (op == OP_JMP_NEAR) || (op == OP_JMP_FAR)
              || (op == OP_JMP_SHORT) || (op == OP_CALL_FAR)
              || ((op[7:4] == OP_RET_INT_HI) && (op[3:0] inside {4'h2, 4'h3, 4'ha,
                  4'hb, 4'hc, 4'hd, 4'hf}));
      // forms carrying an addressing byte
      if (cls_mov || cls_movi || cls_seg || cls_exchange_instruction || cls_imm || cls_esc) begin
         mem = (md != MOD_REGISTER);
         // displacement sits right after the addressing byte
         if (md == MOD_DISP8) begin
            dec_nxt.disp_len = 2'h1;
            dec_nxt.disp     = {{8{i_instr.tail[7]}}, i_instr.tail[7:0]};
            after            = {8'h00, i_instr.tail[31:8]};
         end else if (md == MOD_DISP16 || (md == MOD_NO_DISP && rm == RM_DIRECT)) begin
            dec_nxt.disp_len = 2'h2;
            dec_nxt.disp     = i_instr.tail[15:0];
            after            = {16'h0000, i_instr.tail[31:16]};
         end else begin
            after            = i_instr.tail;
         end
      end
      dec_nxt.mem_operand = mem;
      dec_nxt.word_op     = op[0];
      dec_nxt.reg_is_dest = cls_mov ? op[1] : 1'b0;
      // immediate data follows any displacement
      if (cls_imm) begin
         if (op[1]) begin
            dec_nxt.imm_len = 2'h1;
            dec_nxt.imm     = {{8{after[7]}}, after[7:0]};
         end else if (op[0]) begin
            dec_nxt.imm_len = 2'h2;
            dec_nxt.imm     = after[15:0];
         end else begin
            dec_nxt.imm_len = 2'h1;
            dec_nxt.imm     = {8'h00, after[7:0]};
         end
      end else if (cls_movi) begin
         dec_nxt.imm_len = op[0] ? 2'h2 : 2'h1;
         dec_nxt.imm     = op[0] ? after[15:0] : {8'h00, after[7:0]};
      end
      // cycle count selection per form
      if (cls_mov && op[1]) begin
         reg_c = CYC_MOV_TO_R;
         mem_c = CYC_MOV_TO_R_M;
      end else if (cls_mov || cls_movi) begin
         reg_c = CYC_MOV_TO_RM;
         mem_c = CYC_MOV_TO_RM_M;
      end else if (cls_seg) begin
         reg_c = i_env.protected_mode ? CYC_SEG_PROT : CYC_SEG_REAL;
         mem_c = i_env.protected_mode ? CYC_SEG_PROT_M : CYC_SEG_REAL_M;
      end else if (cls_exchange_instruction) begin
         reg_c = CYC_EXCHANGE_INSTRUCTION;
         mem_c = CYC_EXCHANGE_INSTRUCTION_M;
      end else if (cls_imm) begin
         reg_c = CYC_IMM_GRP;
         mem_c = CYC_IMM_GRP_M;
      end else if (cls_pop_flag_word_instruction) begin
         reg_c = CYC_POP_FLAGS;
         mem_c = CYC_POP_FLAGS;
      end else if (cls_port) begin
         reg_c = op[1] ? CYC_PORT_OUT : CYC_PORT_IN;
         mem_c = reg_c;
      end
      dec_nxt.cycles = mem ? mem_c : reg_c;
      // base plus index plus displacement costs one more
      if (mem && (md != MOD_NO_DISP) && !rm[2]) begin
         dec_nxt.cycles = dec_nxt.cycles + CYC_THREE_TERM;
      end
      // exchange locks by itself; descriptor fetches lock in protected mode
      lock_nxt = cls_exchange_instruction
              || (i_env.protected_mode && i_env.descriptor_access);
      // fault checks, first match wins
      if (!i_env.protected_mode) begin
         if (cls_sys) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_UNDEF_OP;
         end else if (cls_esc && mem && i_env.limit_violation) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_PX_OVRUN;
         end else if (mem && op[0] && !cls_esc && i_env.operand_offset == WORD_LAST_OFFSET) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_GEN_PROT;
         end
      end else begin
         if (cls_ctl && !i_env.target_in_limit) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_GEN_PROT;
         end else if (cls_port && (i_env.current_privilege_level >
                                   i_env.port_privilege_threshold)) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_GEN_PROT;
         end else if (mem && i_env.stack_violation) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_STACK;
         end else if (mem && (i_env.limit_violation || i_env.access_violation)) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_GEN_PROT;
         end else if (cls_seg && !i_env.selector_priv_ok) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_GEN_PROT;
         end else if (cls_seg && !i_env.seg_present) begin
            fault_nxt = 1'b1;
            vec_nxt   = i_env.dest_is_stack_seg ? VEC_STACK : VEC_NOT_PRES;
         end else if (cls_esc && i_env.transfer_overrun) begin
            fault_nxt = 1'b1;
            vec_nxt   = VEC_PX_OVRUN;
         end else if (cls_sys && !i_env.selector_priv_ok) begin
            // selector checks report by flag, never by fault
            dec_nxt.no_result   = 1'b1;
            flags_nxt[FLG_ZERO] = 1'b0;
         end
      end
      // flag word pop, filtered by mode and privilege
      if (cls_pop_flag_word_instruction) begin
         flags_nxt = i_popped_flags;
         if (!i_env.protected_mode) begin
            flags_nxt[FLG_PPT +: 2] = 2'h0;
            flags_nxt[FLG_NEST]     = 1'b0;
         end else begin
            if (i_env.current_privilege_level > i_env.port_privilege_threshold) begin
               flags_nxt[FLG_INT] = i_cur_flags[FLG_INT];
            end
            if (i_env.current_privilege_level != 2'h0) begin
               flags_nxt[FLG_PPT +: 2] = i_cur_flags[FLG_PPT +: 2];
            end
         end
      end
   end

   // handshake state: a fault blocks new instructions until it is taken
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_r <= DTD_RUN;
         o_ready <= 1'b1;
      end else begin
         unique case (state_r)
            DTD_RUN: begin
               if (accept && fault_nxt) begin
                  state_r <= DTD_FAULT_WAIT;
                  o_ready <= 1'b0;
               end
            end
            DTD_FAULT_WAIT: begin
               if (i_fault_ready) begin
                  state_r <= DTD_RUN;
                  o_ready <= 1'b1;
               end
            end
         endcase
      end
   end

   // fault vector held stable until the exception unit takes it
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_fault_valid  <= 1'b0;
         o_fault_vector <= 8'h00;
      end else if (accept && fault_nxt) begin
         o_fault_valid  <= 1'b1;
         o_fault_vector <= vec_nxt;
      end else if (o_fault_valid && i_fault_ready) begin
         o_fault_valid  <= 1'b0;
      end
   end

   // results leave only for a clean instruction; a fault commits nothing
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_commit <= 1'b0;
         o_dec    <= '0;
         o_flags  <= 16'h0000;
      end else begin
         o_commit <= accept && !fault_nxt;
         if (accept && !fault_nxt) begin
            o_dec   <= dec_nxt;
            o_flags <= flags_nxt;
         end
      end
   end

   // lock is per instruction; it is free to fall between transfers
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_lock <= 1'b0;
      end else begin
         o_lock <= accept && !fault_nxt && lock_nxt;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   chk_dir_bit: assert property (accept && !fault_nxt
      && i_instr.opcode[7:2] == OP_MOV_RM
      |=> o_commit && o_dec.reg_is_dest == $past(i_instr.opcode[1]))
      else $error("direction bit not honoured");
   chk_width_bit: assert property (accept && !fault_nxt
      |=> o_dec.word_op == $past(i_instr.opcode[0]))
      else $error("width bit not honoured");
   chk_sign_ext: assert property (accept && !fault_nxt
      && i_instr.opcode[7:2] == OP_IMM_GRP && i_instr.opcode[1]
      && i_instr.modrm[7:6] == MOD_REGISTER
      |=> o_dec.imm_len == 2'h1
      && o_dec.imm == {{8{$past(i_instr.tail[7])}}, $past(i_instr.tail[7:0])})
      else $error("byte immediate not sign extended");
   chk_seg_cycles: assert property (accept && !fault_nxt
      && i_instr.opcode == OP_SEG_LOAD
      && i_env.protected_mode && i_instr.modrm[7:6] == MOD_REGISTER
      |=> o_dec.cycles == CYC_SEG_PROT)
      else $error("protected segment load cycle count wrong");
   chk_undef_real: assert property (accept && !i_env.protected_mode
      && i_instr.opcode == OP_TWO_BYTE
      |=> o_fault_valid && o_fault_vector == VEC_UNDEF_OP && !o_commit)
      else $error("protected-only opcode not trapped");
   chk_word_wrap: assert property (accept && !i_env.protected_mode
      && i_instr.opcode[7:1] == OP_EXCHANGE_INSTRUCTION_RM && i_instr.opcode[0]
      && i_instr.modrm[7:6] != MOD_REGISTER && i_env.operand_offset == WORD_LAST_OFFSET
      |=> o_fault_valid && o_fault_vector == VEC_GEN_PROT)
      else $error("word access at last offset wrapped");
   chk_flag_real: assert property (accept && !fault_nxt && !i_env.protected_mode
      && i_instr.opcode == OP_POP_FLAGS
      |=> o_flags[FLG_PPT +: 2] == 2'h0 && !o_flags[FLG_NEST])
      else $error("real mode flag pop leaked privilege bits");
   chk_exchange_instruction_lock: assert property (accept && !fault_nxt
      && i_instr.opcode[7:1] == OP_EXCHANGE_INSTRUCTION_RM |=> o_lock)
      else $error("exchange ran without lock");
   chk_port_priv: assert property (accept && i_env.protected_mode
      && i_instr.opcode[7:4] == OP_PORT_HI && i_instr.opcode[2]
      && i_env.current_privilege_level > i_env.port_privilege_threshold
      |=> o_fault_valid && o_fault_vector == VEC_GEN_PROT && !o_ready)
      else $error("port access above threshold not trapped");
   chk_fault_hold: assert property (o_fault_valid && !i_fault_ready
      |=> o_fault_valid && $stable(o_fault_vector) && !o_commit)
      else $error("fault vector dropped before handshake");
   // base plus index plus displacement must cost the extra cycle
   chk_three_term: assert property (accept && !fault_nxt
      && i_instr.opcode[7:2] == OP_MOV_RM && i_instr.opcode[1]
      && i_instr.modrm[7:6] == MOD_DISP8 && !i_instr.modrm[2]
      |=> o_dec.cycles == CYC_MOV_TO_R_M + CYC_THREE_TERM)
      else $error("three-term offset cycle missing");
   chk_reg_count: assert property (accept && !fault_nxt
      && i_instr.opcode[7:2] == OP_MOV_RM && !i_instr.opcode[1]
      && i_instr.modrm[7:6] == MOD_REGISTER |=> o_dec.cycles == CYC_MOV_TO_RM)
      else $error("register operand not charged the lower count");
   // displacement bytes are consumed before the immediate word
   chk_disp_first: assert property (accept && !fault_nxt
      && i_instr.opcode[7:2] == OP_IMM_GRP && !i_instr.opcode[1] && i_instr.opcode[0]
      && i_instr.modrm[7:6] == MOD_DISP16 |=> o_dec.disp == $past(i_instr.tail[15:0])
      && o_dec.imm == $past(i_instr.tail[31:16]))
      else $error("displacement not taken ahead of immediate");
   chk_stack_fault: assert property (accept && i_env.protected_mode
      && i_instr.opcode[7:2] == OP_MOV_RM && i_instr.modrm[7:6] != MOD_REGISTER
      && i_env.stack_violation |=> o_fault_valid && o_fault_vector == VEC_STACK)
      else $error("stack limit breach not trapped");
   chk_seg_absent: assert property (accept && i_env.protected_mode
      && i_instr.opcode == OP_SEG_LOAD && i_instr.modrm[7:6] == MOD_REGISTER
      && i_env.selector_priv_ok && !i_env.seg_present && !i_env.dest_is_stack_seg
      |=> o_fault_valid && o_fault_vector == VEC_NOT_PRES)
      else $error("absent segment not trapped");
   chk_sel_no_fault: assert property (accept && i_env.protected_mode
      && i_instr.opcode == OP_TWO_BYTE && !i_env.selector_priv_ok
      |=> o_commit && !o_fault_valid && o_dec.no_result && !o_flags[FLG_ZERO])
      else $error("selector check faulted or kept zero flag");
   chk_ctl_limit: assert property (accept && i_env.protected_mode
      && i_instr.opcode == OP_JMP_NEAR && !i_env.target_in_limit
      |=> o_fault_valid && o_fault_vector == VEC_GEN_PROT)
      else $error("transfer outside code limit not trapped");

   cov_fault_taken: cover property (o_fault_valid ##1 i_fault_ready ##1 o_ready);
   cov_seg_absent:  cover property (o_fault_valid && o_fault_vector == VEC_NOT_PRES);
   cov_locked_exchange_instruction: cover property (o_commit && o_lock);
   cov_sel_check:   cover property (o_commit && o_dec.no_result);
   cov_slow_take:   cover property ((o_fault_valid && !i_fault_ready) [*3]);
endmodule

// ==== src/dtd_pkg.sv ====
package dtd_pkg;
   // opcode patterns of the data-transfer group and neighbours
   localparam logic [7:0] OP_TWO_BYTE   = 8'h0f;  // system group, protected mode only
   localparam logic [7:0] OP_SEG_LOAD   = 8'h8e;  // register/memory to segment register
   localparam logic [7:0] OP_POP_FLAGS  = 8'h9d;  // pop flag word
   localparam logic [6:0] OP_MOV_R_RM   = 7'h44;  // 1000100w / 1000101w share bits 7:2
   localparam logic [5:0] OP_MOV_RM     = 6'h22;  // 100010dw
   localparam logic [6:0] OP_MOV_IMM_RM = 7'h63;  // 1100011w
   localparam logic [6:0] OP_EXCHANGE_INSTRUCTION_RM    = 7'h43;  // 1000011w
   localparam logic [5:0] OP_IMM_GRP    = 6'h20;  // 100000sw
   localparam logic [3:0] OP_PORT_HI    = 4'he;   // 1110x1xw port input/output
   localparam logic [4:0] OP_ESCAPE     = 5'h1b;  // 11011xxx coprocessor escape
   // control transfers that must land inside the code limit
   localparam logic [7:0] OP_CALL_NEAR  = 8'he8;
   localparam logic [7:0] OP_JMP_NEAR   = 8'he9;
   localparam logic [7:0] OP_JMP_FAR    = 8'hea;
   localparam logic [7:0] OP_JMP_SHORT  = 8'heb;
   localparam logic [7:0] OP_CALL_FAR   = 8'h9a;
   localparam logic [3:0] OP_RET_INT_HI = 4'hc;   // c2,c3,ca,cb,cc,cd,cf

   // addressing byte fields
   localparam logic [1:0] MOD_NO_DISP   = 2'h0;
   localparam logic [1:0] MOD_DISP8     = 2'h1;
   localparam logic [1:0] MOD_DISP16    = 2'h2;
   localparam logic [1:0] MOD_REGISTER  = 2'h3;
   localparam logic [2:0] RM_DIRECT     = 3'h6;

   // exception vectors
   localparam logic [7:0] VEC_UNDEF_OP  = 8'h06;
   localparam logic [7:0] VEC_PX_OVRUN  = 8'h09;
   localparam logic [7:0] VEC_NOT_PRES  = 8'h0b;
   localparam logic [7:0] VEC_STACK     = 8'h0c;
   localparam logic [7:0] VEC_GEN_PROT  = 8'h0d;

   // cycle counts: register form, memory form
   localparam logic [4:0] CYC_MOV_TO_RM  = 5'h02, CYC_MOV_TO_RM_M  = 5'h03;
   localparam logic [4:0] CYC_MOV_TO_R   = 5'h02, CYC_MOV_TO_R_M   = 5'h05;
   localparam logic [4:0] CYC_SEG_REAL   = 5'h02, CYC_SEG_REAL_M   = 5'h05;
   localparam logic [4:0] CYC_SEG_PROT   = 5'h11, CYC_SEG_PROT_M   = 5'h13;
   localparam logic [4:0] CYC_EXCHANGE_INSTRUCTION       = 5'h03, CYC_EXCHANGE_INSTRUCTION_M       = 5'h05;
   localparam logic [4:0] CYC_IMM_GRP    = 5'h03, CYC_IMM_GRP_M    = 5'h07;
   localparam logic [4:0] CYC_DEFAULT    = 5'h02, CYC_DEFAULT_M    = 5'h07;
   localparam logic [4:0] CYC_POP_FLAGS  = 5'h05;
   localparam logic [4:0] CYC_PORT_IN    = 5'h05;
   localparam logic [4:0] CYC_PORT_OUT   = 5'h03;
   localparam logic [4:0] CYC_THREE_TERM = 5'h01;

   // flag word fields
   localparam int FLG_ZERO = 6;
   localparam int FLG_INT  = 9;
   localparam int FLG_PPT  = 12;  // two bits, 13:12
   localparam int FLG_NEST = 14;
   localparam logic [15:0] WORD_LAST_OFFSET = 16'hffff;

   typedef enum logic [0:0] {DTD_RUN, DTD_FAULT_WAIT} dtd_state_t;

   // one instruction as presented by the prefetch queue
   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  modrm;
      logic [31:0] tail;     // bytes after the addressing byte, first in 7:0
   } dtd_instr_t;

   // machine state and check results that travel with the instruction
   typedef struct packed {
      logic        protected_mode;
      logic [1:0]  current_privilege_level;
      logic [1:0]  port_privilege_threshold;
      logic [15:0] operand_offset;
      logic        limit_violation;
      logic        access_violation;
      logic        stack_violation;
      logic        seg_present;
      logic        selector_priv_ok;
      logic        dest_is_stack_seg;
      logic        target_in_limit;
      logic        descriptor_access;
      logic        transfer_overrun;
   } dtd_env_t;

   // decoded result handed to execution
   typedef struct packed {
      logic        reg_is_dest;
      logic        word_op;
      logic        mem_operand;
      logic [1:0]  disp_len;
      logic [15:0] disp;
      logic [1:0]  imm_len;
      logic [15:0] imm;
      logic [4:0]  cycles;
      logic        no_result;
   } dtd_dec_t;
endpackage

// ==== verification/dtd_decoder_tb.sv ====
module dtd_decoder_tb import dtd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, rst, valid, slow;  // clock, reset, request, stall select
   dtd_instr_t  instr;                       // instruction bytes
   dtd_env_t    env;                         // machine state and checks
   logic [15:0] cur_flags, popped_flags;     // flag words in
   logic        ready, commit, lock, fault_valid, fault_ready;
   dtd_dec_t    dec;                         // decoded result
   logic [15:0] flags;                       // flag word out
   logic [7:0]  fault_vector;                // exception vector
   int          n_mismatch, cmp_count;
   dtd_decoder i_dtd_decoder (.i_core_clk(core_clk), .i_rst(rst), .i_valid(valid),
      .i_instr(instr), .i_env(env), .i_cur_flags(cur_flags), .i_popped_flags(popped_flags),
      .o_ready(ready), .o_commit(commit), .o_dec(dec), .o_flags(flags), .o_lock(lock),
      .o_fault_valid(fault_valid), .o_fault_vector(fault_vector), .i_fault_ready(fault_ready));
   dtd_exc_model i_dtd_exc_model (.i_core_clk(core_clk), .i_rst(rst),
      .i_fault_valid(fault_valid), .i_slow(slow), .o_fault_ready(fault_ready));
   // 40 MHz clock
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   // verdict and end of run
   task automatic complete_run;
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one compare for every kind of value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a clean environment with every check passing
   function automatic dtd_env_t env_ok(input logic pm);
      dtd_env_t e;
      e = '0;
      e.protected_mode   = pm;
      e.seg_present      = 1'b1;
      e.selector_priv_ok = 1'b1;
      e.target_in_limit  = 1'b1;
      return e;
   endfunction
   // present one instruction for a single edge; outputs are settled on return
   task automatic issue(input logic [7:0] op, md, input logic [31:0] tl, input dtd_env_t e);
      @(posedge core_clk);
      #1;
      instr = '{op, md, tl};
      env   = e;
      valid = 1'b1;
      @(posedge core_clk);
      #1;
      valid = 1'b0;
   endtask
   // faulting instruction, then the handshake; decode state must not move
   task automatic fault_case(input logic [7:0] op, md, input dtd_env_t e, input logic [7:0] v);
      logic [15:0] keep;
      int          n;
      keep = flags;
      issue(op, md, 32'h0, e);
      chk(fault_valid, 1'b1);
      chk(fault_vector, v);
      chk(commit, 1'b0);
      chk(ready, 1'b0);
      for (n = 0; n < 20 && fault_valid !== 1'b0; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk(ready, 1'b1);
      chk(flags, keep);
   endtask
   // operand direction, width, displacement, immediate and cycle counts
   task automatic t_decode;
      issue(8'h8b, 8'h40, 32'h5, env_ok(1'b0));
      chk(dec.reg_is_dest, 1'b1);
      chk(dec.word_op, 1'b1);
      chk(dec.disp, 16'h0005);
      chk(dec.cycles, CYC_MOV_TO_R_M + CYC_THREE_TERM);
      issue(8'h88, 8'hc0, 32'h0, env_ok(1'b0));
      chk(dec.reg_is_dest, 1'b0);
      chk(dec.word_op, 1'b0);
      chk(dec.cycles, CYC_MOV_TO_RM);
      issue(8'h83, 8'hc0, 32'hf0, env_ok(1'b0));
      chk({dec.imm_len, dec.imm}, {2'h1, 16'hfff0});
      issue(8'h81, 8'h86, 32'habcd1234, env_ok(1'b0));
      chk(dec.disp, 16'h1234);
      chk({dec.imm_len, dec.imm}, {2'h2, 16'habcd});
      chk(dec.cycles, CYC_IMM_GRP_M);
   endtask
   // segment loads, exchange lock and descriptor lock
   task automatic t_seg;
      dtd_env_t e;
      issue(8'h8e, 8'hd8, 32'h0, env_ok(1'b0));
      chk(dec.cycles, CYC_SEG_REAL);
      e = env_ok(1'b1);
      e.descriptor_access = 1'b1;
      issue(8'h8e, 8'h1e, 32'h0, e);
      chk(dec.cycles, CYC_SEG_PROT_M);
      chk(lock, 1'b1);
      issue(8'h87, 8'h07, 32'h0, env_ok(1'b0));
      chk({commit, lock}, 2'h3);
      @(posedge core_clk);
      #1;
      chk(lock, 1'b0);
   endtask
   // flag pop in both modes, and a failed selector check
   task automatic t_flags;
      dtd_env_t e;
      popped_flags = 16'hffff;
      issue(8'h9d, 8'h00, 32'h0, env_ok(1'b0));
      chk(flags[14:12], 3'h0);
      popped_flags = 16'h3200;
      e = env_ok(1'b1);
      e.current_privilege_level = 2'h3;
      issue(8'h9d, 8'h00, 32'h0, e);
      chk(flags[13:9], 5'h00);
      e = env_ok(1'b1);
      e.selector_priv_ok = 1'b0;
      issue(8'h0f, 8'h02, 32'h0, e);
      chk({fault_valid, dec.no_result, flags[6]}, 3'h2);
   endtask
   // every exception vector, prompt then stalled exception unit
   task automatic t_faults;
      dtd_env_t e;
      fault_case(8'h0f, 8'h00, env_ok(1'b0), VEC_UNDEF_OP);
      e = env_ok(1'b0);
      e.operand_offset = 16'hffff;
      fault_case(8'h8b, 8'h06, e, VEC_GEN_PROT);
      e = env_ok(1'b0);
      e.limit_violation = 1'b1;
      e.transfer_overrun = 1'b1;
      fault_case(8'hd8, 8'h07, e, VEC_PX_OVRUN);
      slow = 1'b1;
      e = env_ok(1'b1);
      e.limit_violation = 1'b1;
      fault_case(8'h8b, 8'h07, e, VEC_GEN_PROT);
      e = env_ok(1'b1);
      e.stack_violation = 1'b1;
      fault_case(8'h8b, 8'h46, e, VEC_STACK);
      e = env_ok(1'b1);
      e.seg_present = 1'b0;
      fault_case(8'h8e, 8'hd8, e, VEC_NOT_PRES);
      e.dest_is_stack_seg = 1'b1;
      fault_case(8'h8e, 8'hd0, e, VEC_STACK);
      e = env_ok(1'b1);
      e.current_privilege_level = 2'h3;
      fault_case(8'he4, 8'h00, e, VEC_GEN_PROT);
      e = env_ok(1'b1);
      e.transfer_overrun = 1'b1;
      fault_case(8'hd8, 8'h07, e, VEC_PX_OVRUN);
      e = env_ok(1'b1);
      e.access_violation = 1'b1;
      fault_case(8'hd8, 8'h07, e, VEC_GEN_PROT);
      e = env_ok(1'b1);
      e.target_in_limit = 1'b0;
      fault_case(8'he9, 8'h00, e, VEC_GEN_PROT);
   endtask
   // main sequence: reset for 16 cycles, then every scenario
   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      rst = 1'b1;
      valid = 1'b0;
      slow = 1'b0;
      instr = '0;
      env = '0;
      cur_flags = 16'h0040;
      popped_flags = 16'h0000;
      repeat (16) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_decode;
      t_seg;
      t_flags;
      t_faults;
      complete_run;
   end
   // watchdog: the scenarios need about 115 cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      complete_run;
   end
endmodule

// ==== verification/dtd_exc_model.sv ====
// exception unit model: takes a pending fault at once or after a stall
module dtd_exc_model (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   // fault handshake
   input  wire logic i_fault_valid,
   input  wire logic i_slow,
   output logic      o_fault_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] wait_r;  // cycles the fault has been pending
   // ready drops on the take edge so one fault is never taken twice
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wait_r        <= 3'h0;
         o_fault_ready <= 1'b0;
      end else if (i_fault_valid && !o_fault_ready) begin
         o_fault_ready <= (wait_r >= (i_slow ? 3'h4 : 3'h0));
         wait_r        <= wait_r + 3'h1;
      end else begin
         wait_r        <= 3'h0;
         o_fault_ready <= 1'b0;
      end
   end
endmodule
